// ==== shared/serial_link_bist_pkg.sv ====
package serial_link_bist_pkg;

	// Register port widths.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Recovered payload width; every bit of a payload is expected to be zero in self test.
	localparam int PAYLOAD_W = 35;
	// Largest number of bit errors that one payload can flag.
	localparam int MAX_PAYLOAD_ERR_BITS = 35;
	localparam int POPCOUNT_W = 6;

	// Register offsets.
	localparam logic [7:0] ADDR_LINK_ERR_COUNT = 8'h41;
	localparam logic [7:0] ADDR_CTRL = 8'h42;
	localparam logic [7:0] ADDR_STATUS = 8'h43;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h44;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h45;
	localparam logic [7:0] ADDR_PAYLOAD_ERR_COUNT = 8'h46;

	// Control register fields.
	localparam int CTRL_BIT_SELFTEST_REQ = 0;
	localparam int CTRL_BIT_OSC_25 = 1;
	localparam int CTRL_BIT_LF_OVERRIDE = 2;
	localparam int CTRL_BIT_LF_VALUE = 3;
	localparam int CTRL_W = 4;
	localparam logic [3:0] CTRL_RESET = 4'h0;

	// Status register fields.
	localparam int STAT_BIT_LOCK = 0;
	localparam int STAT_BIT_CHECKING = 1;
	localparam int STAT_BIT_RESULT = 2;
	localparam int STAT_BIT_REMOTE = 3;
	localparam int STAT_BIT_DONE = 4;

	// Interrupt status and mask fields.
	localparam int IRQ_BIT_TEST_DONE = 0;
	localparam int IRQ_BIT_PAYLOAD_ERR = 1;
	localparam int IRQ_BIT_LOCK_LOST = 2;
	localparam int IRQ_W = 3;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

	// Counter widths.
	localparam int LINK_ERR_W = 5;
	localparam int PAYLOAD_ERR_CNT_W = 8;

	// Internal oscillator frequencies in kHz.
	localparam int OSC_NORMAL_KHZ = 33000;
	localparam int OSC_ALT_KHZ = 25000;
	localparam int OSC_LOW_FREQ_KHZ = 12500;

	// Pixel clock ranges in MHz for the two frequency ranges (upper bound of low range exclusive).
	localparam int PCLK_NORMAL_MIN_MHZ = 15;
	localparam int PCLK_NORMAL_MAX_MHZ = 85;
	localparam int PCLK_LOW_MIN_MHZ = 5;
	localparam int PCLK_LOW_MAX_MHZ = 15;

	// Oscillator frequency selection driven to the clock generator.
	typedef enum logic [1:0] {
		OSC_FREQ_33,
		OSC_FREQ_25,
		OSC_FREQ_12P5
	} osc_freq_t;

endpackage : serial_link_bist_pkg

// ==== hdl/bit_sync_2ff.sv ====
`timescale 1ns/10ps

// Two-flop synchroniser for a group of independent levels from outside the clock domain.
module bit_sync_2ff #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// The first stage feeds only the second stage, so metastability has a full cycle to settle.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule : bit_sync_2ff

// ==== hdl/serial_link_bist_checker.sv ====
// Function
// (R1) Enter self test by pin or register.
// (R2) Normal range: pixel clock or 33 MHz oscillator.
// (R3) Register picks oscillator 33 or 25 MHz.
// (R4) Low range: pixel clock or 12.5 MHz oscillator.
// (R5) Forward self-test request over back channel.
// (R6) Serializer sends scrambled all-zeroes pattern.
// (R7) Compare locked payloads with zero, record errors.
// (R8) Both ends ready and locked: flag high.
// (R9) Errored payload drives flag low half period.
// (R10) Request low: stop, flag shows final result.
// (R11) Hold result until new test or reset.
// (R12) Request pulse width sets test duration.
// (R13) Expose link error count and lock status.
// (R14) After test, resume normal video output.
// (R15) Serializer counts back-channel CRC errors, 8 bits.
// (R16) Serializer clears CRC count on test entry.
// (R17) Range select: 15-85 MHz or 5-15 MHz.
// (R18) Link error count at 0x41 bits 4:0.
// (R19) No payload checking while lock is low.
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps

module serial_link_bist_checker
	import serial_link_bist_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic [DATA_W-1:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [DATA_W-1:0] REG_RDATA,
	input wire logic SELFTEST_REQUEST_PIN,
	input wire logic SELFTEST_CLOCK_SELECT,
	input wire logic LOW_FREQ_RANGE_SELECT,
	input wire logic REMOTE_SELFTEST_ACTIVE,
	input wire logic LINK_CLK,
	input wire logic LINK_LOCK,
	input wire logic [PAYLOAD_W-1:0] LINK_PAYLOAD,
	output logic BACKCHANNEL_SELFTEST_REQ,
	output logic TEST_CLOCK_FROM_OSC,
	output logic LOW_FREQ_MODE,
	output osc_freq_t OSC_FREQ_SEL,
	output logic VIDEO_OUTPUT_EN,
	output logic SELFTEST_PASS,
	output logic IRQ
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT_READY,
		ST_CHECK,
		ST_DONE
	} bist_state_t;

	localparam int SYNC_W = PAYLOAD_W + 6;

	// Count of set bits in a payload; any set bit is an error against the all-zeroes pattern.
	function automatic logic [POPCOUNT_W-1:0] count_ones(input logic [PAYLOAD_W-1:0] word);
		logic [POPCOUNT_W-1:0] total;
		total = '0;
		for (int i = 0; i < PAYLOAD_W; i++) begin
			total = total + POPCOUNT_W'(word[i]);
		end
		return total;
	endfunction : count_ones

	logic [SYNC_W-1:0] async_bus;
	logic [SYNC_W-1:0] sync_bus;
	logic pin_req_s;
	logic clk_sel_s;
	logic lf_pin_s;
	logic remote_s;
	logic link_clk_s;
	logic lock_s;
	logic [PAYLOAD_W-1:0] payload_s;

	logic link_clk_d_reg;
	logic lock_d_reg;
	logic req_d_reg;
	logic link_rise;
	logic link_fall;
	logic lock_fall;
	logic selftest_req;
	logic req_rise;
	logic lf_mode;
	logic [POPCOUNT_W-1:0] err_bits;
	logic payload_bad;
	logic check_now;

	bist_state_t state_reg;
	bist_state_t state_next;
	logic run_err_reg;
	logic err_low_reg;
	logic [CTRL_W-1:0] ctrl_reg;
	logic [IRQ_W-1:0] irq_status_reg;
	logic [IRQ_W-1:0] irq_mask_reg;
	logic [IRQ_W-1:0] irq_events;
	logic [LINK_ERR_W-1:0] link_err_reg;
	logic [PAYLOAD_ERR_CNT_W-1:0] payload_err_reg;
	logic [DATA_W-1:0] rdata_next;

	// Every pin outside the register port, clock and reset, and the sampled link clock, pass two flops before any logic looks at them.
	assign async_bus = {LINK_PAYLOAD, LINK_LOCK, LINK_CLK, REMOTE_SELFTEST_ACTIVE,
		LOW_FREQ_RANGE_SELECT, SELFTEST_CLOCK_SELECT, SELFTEST_REQUEST_PIN};

	bit_sync_2ff #(
		.WIDTH(SYNC_W)
	) u_pin_sync (
		.clk(REF_CLK),
		.reset_n(RESET_N),
		.async_in(async_bus),
		.sync_out(sync_bus)
	);

	// Payload and link clock share the same latency, so the payload seen at a detected
	// rising edge is the word that was stable around that edge.
	assign pin_req_s = sync_bus[0];
	assign clk_sel_s = sync_bus[1];
	assign lf_pin_s = sync_bus[2];
	assign remote_s = sync_bus[3];
	assign link_clk_s = sync_bus[4];
	assign lock_s = sync_bus[5];
	assign payload_s = sync_bus[SYNC_W-1:6];

	// Delayed copies for edge detection: link clock and lock from the second synchroniser stage, request from the combined pin and register request.
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			link_clk_d_reg <= 1'b0;
			lock_d_reg <= 1'b0;
			req_d_reg <= 1'b0;
		end else begin
			link_clk_d_reg <= link_clk_s;
			lock_d_reg <= lock_s;
			req_d_reg <= selftest_req;
		end
	end

	assign link_rise = link_clk_s & ~link_clk_d_reg;
	assign link_fall = ~link_clk_s & link_clk_d_reg;
	assign lock_fall = ~lock_s & lock_d_reg;

	// Either the pin or the register bit requests self test.
	assign selftest_req = pin_req_s | ctrl_reg[CTRL_BIT_SELFTEST_REQ]; // (R1)
	assign req_rise = selftest_req & ~req_d_reg;

	// Register override takes precedence over the range pin.
	assign lf_mode = ctrl_reg[CTRL_BIT_LF_OVERRIDE] ? ctrl_reg[CTRL_BIT_LF_VALUE] : lf_pin_s; // (R17)

	// Payload check happens only on a link edge while locked and checking.
	assign err_bits = count_ones(payload_s); // (R7)
	assign payload_bad = (err_bits != '0) && (err_bits <= POPCOUNT_W'(MAX_PAYLOAD_ERR_BITS));
	assign check_now = (state_reg == ST_CHECK) && link_rise && lock_s; // (R19)

	// Test sequencing: a request starts a run, the remote end and lock gate checking.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (selftest_req) begin
					state_next = ST_WAIT_READY;
				end
			end
			ST_WAIT_READY: begin
				if (!selftest_req) begin
					state_next = ST_IDLE;
				end else if (remote_s && lock_s) begin
					state_next = ST_CHECK; // (R8)
				end
			end
			ST_CHECK: begin
				if (!selftest_req) begin
					state_next = ST_DONE; // (R10)
				end
			end
			ST_DONE: begin
				if (req_rise) begin
					state_next = ST_WAIT_READY; // (R11)
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Sticky run error; cleared only when a new run starts.
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			run_err_reg <= 1'b0;
		end else if (state_reg != ST_WAIT_READY && state_next == ST_WAIT_READY) begin
			run_err_reg <= 1'b0; // (R11)
		end else if (check_now && payload_bad) begin
			run_err_reg <= 1'b1; // (R7)
		end
	end

	// The low pulse runs from the link rising edge to its falling edge: half a link period.
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			err_low_reg <= 1'b0;
		end else if (check_now && payload_bad) begin
			err_low_reg <= 1'b1; // (R9)
		end else if (link_fall || state_reg != ST_CHECK) begin
			err_low_reg <= 1'b0; // (R9)
		end
	end

	// Result flag: high while checking clean, pulsed low on errors, then holds the outcome.
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			SELFTEST_PASS <= 1'b0;
		end else begin
			case (state_reg)
				ST_CHECK: SELFTEST_PASS <= ~err_low_reg; // (R8)
				ST_DONE: SELFTEST_PASS <= ~run_err_reg; // (R10)
				default: SELFTEST_PASS <= 1'b0;
			endcase
		end
	end

	// Back-channel request mirrors the request level; it also wakes a sleeping serializer.
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			BACKCHANNEL_SELFTEST_REQ <= 1'b0;
		end else begin
			BACKCHANNEL_SELFTEST_REQ <= selftest_req; // (R5)
		end
	end

	// Test clock source and oscillator frequency follow the select pin and range.
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			TEST_CLOCK_FROM_OSC <= 1'b0;
			LOW_FREQ_MODE <= 1'b0;
			OSC_FREQ_SEL <= OSC_FREQ_33;
		end else begin
			TEST_CLOCK_FROM_OSC <= clk_sel_s; // (R1)
			LOW_FREQ_MODE <= lf_mode; // (R17)
			if (lf_mode) begin
				OSC_FREQ_SEL <= OSC_FREQ_12P5; // (R4)
			end else if (ctrl_reg[CTRL_BIT_OSC_25]) begin
				OSC_FREQ_SEL <= OSC_FREQ_25; // (R3)
			end else begin
				OSC_FREQ_SEL <= OSC_FREQ_33; // (R2)
			end
		end
	end

	// Video is driven only outside an active run, so the pattern never reaches the outputs.
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			VIDEO_OUTPUT_EN <= 1'b1;
		end else begin
			VIDEO_OUTPUT_EN <= (state_next == ST_IDLE) || (state_next == ST_DONE); // (R14)
		end
	end

	// Lock losses count as link breaks; the counter saturates rather than wraps.
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			link_err_reg <= '0;
		end else if (req_rise) begin
			link_err_reg <= '0;
		end else if (lock_fall && link_err_reg != '1) begin
			link_err_reg <= link_err_reg + LINK_ERR_W'(1); // (R13)
		end
	end

	// Errored payloads per run, saturating.
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			payload_err_reg <= '0;
		end else if (req_rise) begin
			payload_err_reg <= '0;
		end else if (check_now && payload_bad && payload_err_reg != '1) begin
			payload_err_reg <= payload_err_reg + PAYLOAD_ERR_CNT_W'(1); // (R7)
		end
	end

	// Control and mask registers written by software.
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl_reg <= CTRL_RESET;
			irq_mask_reg <= IRQ_MASK_RESET;
		end else if (REG_WR) begin
			if (REG_ADDR == ADDR_CTRL) begin
				ctrl_reg <= REG_WDATA[CTRL_W-1:0];
			end
			if (REG_ADDR == ADDR_IRQ_MASK) begin
				irq_mask_reg <= REG_WDATA[IRQ_W-1:0];
			end
		end
	end

	assign irq_events[IRQ_BIT_TEST_DONE] = (state_reg == ST_CHECK) && (state_next == ST_DONE);
	assign irq_events[IRQ_BIT_PAYLOAD_ERR] = check_now && payload_bad;
	assign irq_events[IRQ_BIT_LOCK_LOST] = lock_fall;

	// A read clears the sticky bits, but an event in the same cycle still sets its bit.
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			irq_status_reg <= '0;
		end else if (REG_RD && REG_ADDR == ADDR_IRQ_STATUS) begin
			irq_status_reg <= irq_events;
		end else begin
			irq_status_reg <= irq_status_reg | irq_events;
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(irq_status_reg & irq_mask_reg);
		end
	end

	// Read multiplexer; unmapped addresses read as zero.
	always_comb begin
		rdata_next = '0;
		case (REG_ADDR)
			ADDR_LINK_ERR_COUNT: rdata_next[LINK_ERR_W-1:0] = link_err_reg; // (R18)
			ADDR_CTRL: rdata_next[CTRL_W-1:0] = ctrl_reg;
			ADDR_STATUS: begin
				rdata_next[STAT_BIT_LOCK] = lock_s; // (R13)
				rdata_next[STAT_BIT_CHECKING] = (state_reg == ST_CHECK);
				rdata_next[STAT_BIT_RESULT] = SELFTEST_PASS;
				rdata_next[STAT_BIT_REMOTE] = remote_s;
				rdata_next[STAT_BIT_DONE] = (state_reg == ST_DONE);
			end
			ADDR_IRQ_STATUS: rdata_next[IRQ_W-1:0] = irq_status_reg;
			ADDR_IRQ_MASK: rdata_next[IRQ_W-1:0] = irq_mask_reg;
			ADDR_PAYLOAD_ERR_COUNT: rdata_next = payload_err_reg;
			default: rdata_next = '0;
		endcase
	end

	// Read data stands for exactly the cycle after the strobe and is zero otherwise.
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			REG_RDATA <= '0;
		end else if (REG_RD) begin
			REG_RDATA <= rdata_next;
		end else begin
			REG_RDATA <= '0;
		end
	end

endmodule : serial_link_bist_checker

// ==== dv/serial_link_bist_checker_assertions.sv ====
`timescale 1ns/10ps

// Port-level checks of the self-test result flag, request forwarding and clock selection.
module serial_link_bist_checker_assertions
	import serial_link_bist_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic SELFTEST_REQUEST_PIN,
	input wire logic SELFTEST_CLOCK_SELECT,
	input wire logic LINK_LOCK,
	input wire logic BACKCHANNEL_SELFTEST_REQ,
	input wire logic TEST_CLOCK_FROM_OSC,
	input wire logic LOW_FREQ_MODE,
	input wire osc_freq_t OSC_FREQ_SEL,
	input wire logic VIDEO_OUTPUT_EN,
	input wire logic SELFTEST_PASS
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);

	// A run counts as settled once the request has stood for four cycles.
	sequence req_held;
		BACKCHANNEL_SELFTEST_REQ [*4];
	endsequence
	// An error pulse lasts half a link period, four reference cycles here.
	sequence err_pulse;
		!SELFTEST_PASS [*3] ##[1:2] SELFTEST_PASS;
	endsequence

	pin_forward_a: assert property ($rose(SELFTEST_REQUEST_PIN) |-> ##[1:5] BACKCHANNEL_SELFTEST_REQ)
		else $error("request pin not forwarded");
	clock_select_a: assert property ($rose(SELFTEST_CLOCK_SELECT) |-> ##[1:5] TEST_CLOCK_FROM_OSC)
		else $error("clock source select not followed");
	video_off_a: assert property (BACKCHANNEL_SELFTEST_REQ [*3] |-> !VIDEO_OUTPUT_EN)
		else $error("video output left on during test");
	video_back_a: assert property ($fell(BACKCHANNEL_SELFTEST_REQ) |-> ##[0:3] VIDEO_OUTPUT_EN)
		else $error("video output not resumed");
	pass_source_a: assert property ($rose(SELFTEST_PASS) |-> BACKCHANNEL_SELFTEST_REQ)
		else $error("result flag rose outside a test");
	pass_hold_a: assert property (!BACKCHANNEL_SELFTEST_REQ [*4] |=> $stable(SELFTEST_PASS))
		else $error("final result not held");
	err_pulse_a: assert property (req_held ##0 $fell(SELFTEST_PASS) |-> err_pulse)
		else $error("error pulse length wrong");
	lock_quiet_a: assert property ((!LINK_LOCK && BACKCHANNEL_SELFTEST_REQ) [*6] |-> !$fell(SELFTEST_PASS))
		else $error("error pulse while unlocked");
	range_low_a: assert property (LOW_FREQ_MODE [*2] |-> OSC_FREQ_SEL == OSC_FREQ_12P5)
		else $error("low range oscillator wrong");
	range_norm_a: assert property (!LOW_FREQ_MODE [*2] |-> OSC_FREQ_SEL != OSC_FREQ_12P5)
		else $error("normal range oscillator wrong");
endmodule : serial_link_bist_checker_assertions

bind serial_link_bist_checker serial_link_bist_checker_assertions sva_i (.REF_CLK, .RESET_N,
	.SELFTEST_REQUEST_PIN, .SELFTEST_CLOCK_SELECT, .LINK_LOCK, .BACKCHANNEL_SELFTEST_REQ,
	.TEST_CLOCK_FROM_OSC, .LOW_FREQ_MODE, .OSC_FREQ_SEL, .VIDEO_OUTPUT_EN, .SELFTEST_PASS);

// ==== dv/serializer_model.sv ====
`timescale 1ns/10ps

// Far-end serializer: follows the self-test request and streams payloads with the low err_bits bits set, zero when err_bits is zero.
module serializer_model
	import serial_link_bist_pkg::*;
(
	input wire logic req,
	input wire logic lock_en,
	input wire logic [5:0] err_bits,
	output logic active,
	output logic link_clk,
	output logic lock,
	output logic [PAYLOAD_W-1:0] payload,
	output logic [7:0] crc_err_count
);
	logic [PAYLOAD_W-1:0] word_reg;
	// Start asleep with the link clock parked low.
	initial begin
		active = 1'b0;
		link_clk = 1'b0;
		word_reg = '0;
		crc_err_count = 8'h00;
	end
	// Waking and switching mode take a while, as on a real far end.
	always @(req) active <= #300 req;
	// The link clock runs only in a test, at a phase unrelated to the bench clock.
	initial begin
		#7;
		forever #80 link_clk = active ? ~link_clk : 1'b0;
	end
	assign lock = active & lock_en;
	// The next word is built on the falling edge, so it is steady at the rise that samples it.
	always @(negedge link_clk) begin
		if (active) begin
			word_reg <= (PAYLOAD_W'(1) << err_bits) - PAYLOAD_W'(1);
		end
	end
	// An unlocked receiver sees garbage; it switches together with lock, never ahead of it.
	assign payload = lock ? word_reg : '1;
	// The back channel is clean here, so the count only restarts on entry.
	always @(posedge active) crc_err_count <= 8'h00;
endmodule : serializer_model

// ==== dv/tb_serial_link_bist_checker.sv ====
`timescale 1ns/10ps

module tb_serial_link_bist_checker
	import serial_link_bist_pkg::*;
;
	logic clk, rst_n, wr, rd, pin, csel, lfsel, lock_en, req, act, lclk, lock, irq;
	logic tosc, lfm, ven, pass;
	logic [7:0] addr, wdata, rdata;
	logic [5:0] err;
	logic [PAYLOAD_W-1:0] pay;
	osc_freq_t osel;
	int n_errors, tests_run;

	serial_link_bist_checker uut (.REF_CLK(clk), .RESET_N(rst_n), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
		.SELFTEST_REQUEST_PIN(pin), .SELFTEST_CLOCK_SELECT(csel),
		.LOW_FREQ_RANGE_SELECT(lfsel), .REMOTE_SELFTEST_ACTIVE(act), .LINK_CLK(lclk),
		.LINK_LOCK(lock), .LINK_PAYLOAD(pay), .BACKCHANNEL_SELFTEST_REQ(req),
		.TEST_CLOCK_FROM_OSC(tosc), .LOW_FREQ_MODE(lfm), .OSC_FREQ_SEL(osel),
		.VIDEO_OUTPUT_EN(ven), .SELFTEST_PASS(pass), .IRQ(irq));
	serializer_model far (.req(req), .lock_en(lock_en), .err_bits(err), .active(act),
		.link_clk(lclk), .lock(lock), .payload(pay), .crc_err_count());

	// Counts every compare and reports a mismatch at once.
	task automatic chk(input logic [34:0] seen, input logic [34:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	// Read data stand only in the cycle after the strobe, so they are taken mid-cycle there.
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, exp);
	endtask : rd_reg
	// Pins pass a synchroniser, so six cycles are allowed before looking.
	task automatic pins(input logic p, input logic c, input logic l);
		@(posedge clk);
		pin <= p;
		csel <= c;
		lfsel <= l;
		repeat (6) @(negedge clk);
	endtask : pins
	task automatic wait_pass(input logic v);
		int n;
		n = 0;
		while (pass !== v && n < 300) begin
			@(negedge clk);
			n++;
		end
		chk(pass, v);
	endtask : wait_pass
	// One errored payload, sent between two link clock rises.
	task automatic inject(input logic [5:0] bits);
		@(posedge lclk);
		err = bits;
		@(posedge lclk);
		err = 6'h00;
		wait_pass(1'b0);
		wait_pass(1'b1);
	endtask : inject
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : print_verdict

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// The whole run takes about 12 us; this limit leaves ample margin.
	initial begin
		#500000;
		n_errors++;
		print_verdict();
	end
	// Main sequence.
	initial begin
		{rst_n, wr, rd, pin, csel, lfsel, addr, wdata, err} = '0;
		lock_en = 1'b1;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk({ven, pass, osel, req}, 5'b10000);
		rd_reg(ADDR_CTRL, 8'h00);
		rd_reg(ADDR_IRQ_MASK, 8'h00);
		rd_reg(8'h00, 8'h00);
		$display("test reset done");
		pins(1'b0, 1'b1, 1'b1);
		chk({tosc, lfm, osel}, {2'b11, OSC_FREQ_12P5});
		wr_reg(ADDR_CTRL, 8'h06);
		rd_reg(ADDR_CTRL, 8'h06);
		chk({lfm, osel}, {1'b0, OSC_FREQ_25});
		wr_reg(ADDR_CTRL, 8'h00);
		pins(1'b0, 1'b0, 1'b0);
		chk({tosc, lfm, osel}, {2'b00, OSC_FREQ_33});
		wr_reg(ADDR_CTRL, 8'h0C);
		repeat (2) @(negedge clk);
		chk({lfm, osel}, {1'b1, OSC_FREQ_12P5});
		wr_reg(ADDR_CTRL, 8'h00);
		$display("test clock source done");
		wr_reg(ADDR_IRQ_MASK, 8'h01);
		pins(1'b1, 1'b0, 1'b0);
		chk({req, ven}, 2'b10);
		wait_pass(1'b1);
		rd_reg(ADDR_STATUS, 8'h0F);
		repeat (100) @(negedge clk);
		chk(pass, 1'b1);
		pins(1'b0, 1'b0, 1'b0);
		chk({pass, ven, irq}, 3'b111);
		rd_reg(ADDR_IRQ_STATUS, 8'h01);
		rd_reg(ADDR_LINK_ERR_COUNT, 8'h00);
		chk(irq, 1'b0);
		$display("test clean run done");
		// Let the far end fall asleep first, or its stale lock would start the next run early.
		repeat (20) @(negedge clk);
		wr_reg(ADDR_IRQ_MASK, 8'h00);
		wr_reg(ADDR_CTRL, 8'h01);
		repeat (3) @(negedge clk);
		chk(pass, 1'b0);
		wait_pass(1'b1);
		inject(6'd1);
		inject(6'd35);
		@(posedge lclk);
		lock_en = 1'b0;
		repeat (60) @(negedge clk);
		chk(pass, 1'b1);
		@(posedge lclk);
		lock_en = 1'b1;
		repeat (60) @(negedge clk);
		chk({pass, irq}, 2'b10);
		wr_reg(ADDR_CTRL, 8'h00);
		repeat (8) @(negedge clk);
		chk({pass, ven}, 2'b01);
		rd_reg(ADDR_LINK_ERR_COUNT, 8'h01);
		rd_reg(ADDR_PAYLOAD_ERR_COUNT, 8'h02);
		rd_reg(ADDR_IRQ_STATUS, 8'h07);
		repeat (200) @(negedge clk);
		chk(pass, 1'b0);
		$display("test errored run done");
		print_verdict();
	end
endmodule : tb_serial_link_bist_checker
